// ===== core/fcd_pkg.sv
// Purpose: shared constants and types of the flash command decoder
// Assumes: 32-bit register port, byte offsets
// Notes:   engine request travels as one packed struct
package fcd_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CMD   = 8'h00;
   localparam logic [7:0] REG_ADDR  = 8'h04;
   localparam logic [7:0] REG_DAT0  = 8'h08;
   localparam logic [7:0] REG_DAT1  = 8'h0C;
   localparam logic [7:0] REG_CNT   = 8'h10;
   localparam logic [7:0] REG_PROT  = 8'h14;
   localparam logic [7:0] REG_STAT  = 8'h18;
   localparam logic [7:0] REG_KEY   = 8'h1C;
   // protection register bit positions
   localparam int PB_LOW  = 0;
   localparam int PB_HIGH = 1;
   localparam int PB_POPN = 2;
   localparam int PB_DOPN = 3;
   // status register bit positions
   localparam int SB_BUSY = 0;
   localparam int SB_DONE = 1;
   localparam int SB_ILL  = 2;
   localparam int SB_VIOL = 3;
   localparam int SB_ACC  = 4;
   localparam int SB_VFAIL = 5;
   localparam int SB_SEC  = 6;
   localparam int SB_POVR = 7;
   localparam int SB_DOVR = 8;
   // command codes
   localparam logic [7:0] C_VFY_ALL = 8'h01;
   localparam logic [7:0] C_VFY_BLK = 8'h02;
   localparam logic [7:0] C_VFY_SEC = 8'h03;
   localparam logic [7:0] C_RD_ONCE = 8'h04;
   localparam logic [7:0] C_PROG    = 8'h06;
   localparam logic [7:0] C_PG_ONCE = 8'h07;
   localparam logic [7:0] C_ERS_ALL = 8'h08;
   localparam logic [7:0] C_ERS_BLK = 8'h09;
   localparam logic [7:0] C_ERS_SEC = 8'h0A;
   localparam logic [7:0] C_UNSEC   = 8'h0B;
   localparam logic [7:0] C_BACKDR  = 8'h0C;
   localparam logic [7:0] C_MRG_USR = 8'h0D;
   localparam logic [7:0] C_MRG_FLD = 8'h0E;
   localparam logic [7:0] C_PROT_OV = 8'h13;
   // one-time field size in bytes
   localparam logic [23:0] ONCE_BYTES = 24'h000040;
   localparam int AW = 24;
   typedef enum logic [3:0] {
      OP_NONE, OP_VFY_ALL, OP_VFY_BLK, OP_VFY_SEC, OP_RD_ONCE, OP_PROG, OP_PG_ONCE,
      OP_ERS_ALL, OP_ERS_BLK, OP_ERS_SEC, OP_MRG_USR, OP_MRG_FLD
   } fcd_op_t;
   typedef struct packed {
      logic          valid;
      fcd_op_t       op;
      logic [AW-1:0] addr;
      logic [63:0]   data;
      logic [15:0]   count;
   } fcd_req_t;
   // decoded view of a command code
   typedef struct packed {
      fcd_op_t op;
      logic    legal;
      logic    unsec;
      logic    backdoor;
      logic    override;
   } fcd_dec_t;
endpackage

// ===== core/fcd_decode.sv
// Purpose: maps a command code onto an engine operation
// Assumes: pure combinational, read in the launch cycle
// Notes:   local commands carry OP_NONE
`timescale 1ns/1ps
module fcd_decode import fcd_pkg::*; (
   input  wire logic [7:0] code,
   output fcd_dec_t        dec
);
   // one entry per supported code, all else refused
   always_comb begin
      dec = '{op: OP_NONE, legal: 1'b1, unsec: 1'b0, backdoor: 1'b0, override: 1'b0};
      case (code)
         C_VFY_ALL: dec.op = OP_VFY_ALL;
         C_VFY_BLK: dec.op = OP_VFY_BLK;
         C_VFY_SEC: dec.op = OP_VFY_SEC;
         C_RD_ONCE: dec.op = OP_RD_ONCE;
         C_PROG:    dec.op = OP_PROG;
         C_PG_ONCE: dec.op = OP_PG_ONCE;
         C_ERS_ALL: dec.op = OP_ERS_ALL;
         C_ERS_BLK: dec.op = OP_ERS_BLK;
         C_ERS_SEC: dec.op = OP_ERS_SEC;
         C_MRG_USR: dec.op = OP_MRG_USR;
         C_MRG_FLD: dec.op = OP_MRG_FLD;
         // unsecure starts as a full erase, verify follows
         C_UNSEC: begin
            dec.op    = OP_ERS_ALL;
            dec.unsec = 1'b1;
         end
         C_BACKDR:  dec.backdoor = 1'b1;
         C_PROT_OV: dec.override = 1'b1;
         default:   dec.legal = 1'b0;
      endcase
   end
endmodule

// ===== core/fcd_key_check.sv
// Purpose: compares a supplied key against the stored key
// Assumes: check is a one-cycle pulse
// Notes:   a failed compare locks further compares until reset
`timescale 1ns/1ps
module fcd_key_check #(
   parameter int KEY_W = 64
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             check,
   input  wire logic [KEY_W-1:0] key_in,
   input  wire logic [KEY_W-1:0] key_ref,
   output logic                  match_ff,
   output logic                  fail_ff,
   output logic                  locked_ff
);
   if (KEY_W < 8) begin : g_chk
      $error("fcd_key_check: KEY_W too small");
   end
   // lockout stops brute-force retries between resets
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         match_ff  <= 1'b0;
         fail_ff   <= 1'b0;
         locked_ff <= 1'b0;
      end else begin
         match_ff <= check && !locked_ff && (key_in == key_ref);
         fail_ff  <= check && (locked_ff || key_in != key_ref);
         if (check && key_in != key_ref) begin
            locked_ff <= 1'b1;
         end
      end
   end
endmodule

// ===== core/fcd_top.sv
// Purpose: flash command decoder and sequencer
// Assumes: engine answers eng_done at least one cycle after a request
// Notes:   special_mode is an outside pin and is synchronised
// Operation
// [R1] code 01 verifies all program and data blocks erased
// [R2] code 02 verifies one program block erased
// [R3] code 03 verifies count words from start address erased
// [R4] code 04 reads the 64 byte one-time field
// [R5] code 06 programs one phrase
// [R6] code 07 programs the 64 byte one-time field, once only
// [R7] code 08 erases all program and data blocks
// [R8] erase-all needs low, high, program open and data open bits set
// [R9] code 09 erases one program or data block
// [R10] full program block erase needs low, high and open bits set
// [R11] code 0A erases one program sector
// [R12] code 0B erases all, verifies, then releases security
// [R13] code 0C compares keys and releases security on match
// [R14] code 0D sets user margin level for program blocks
// [R15] code 0E sets field margin level, special modes only
// [R16] code 13 checks key and overrides program and/or data protection
// [R17] unsupported codes are refused and flagged illegal; while busy the code flags an access error instead
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module fcd_top import fcd_pkg::*; #(
   parameter int KEY_W = 64
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [7:0]       addr,
   input  wire logic [31:0]      wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic [31:0]           rdata_ff,
   output fcd_req_t              eng_req_ff,
   input  wire logic             eng_done,
   input  wire logic             eng_fail,
   input  wire logic [31:0]      eng_rdata,
   input  wire logic             once_used,
   input  wire logic [KEY_W-1:0] nv_key,
   input  wire logic             special_mode,
   output logic                  secured_ff,
   output logic                  busy_ff
);
   if (KEY_W < 8 || KEY_W > 64) begin : g_chk
      $error("fcd_top: KEY_W out of range");
   end

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_ISSUE = 5'h02, ST_WAIT = 5'h04, ST_KEY = 5'h08, ST_FIN = 5'h10
   } fcd_st_t;

   ////////////////////////////////////////////////////////////////////////
   fcd_st_t          st_ff;
   fcd_st_t          nxt_st;
   logic [AW-1:0]    addr_ff;
   logic [63:0]      data_ff;
   logic [15:0]      cnt_ff;
   logic [3:0]       prot_ff;
   logic [63:0]      key_ff;
   logic             done_ff, ill_ff, viol_ff, acc_ff, vfail_ff;
   logic             povr_ff, dovr_ff, unsec_ff, ovr_cmd_ff;
   logic             sm1_ff, sm2_ff, sm3_ff, spec_ff;
   fcd_dec_t         dec;
   logic             launch, accept, refuse_ill, refuse_viol, refuse_acc;
   logic             key_match, key_fail;
   logic             prog_open, data_open, is_data_blk;

   fcd_decode u_dec (
      .code (wdata[7:0]),
      .dec  (dec)
   );

   fcd_key_check #(.KEY_W(KEY_W)) u_key (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .check     (st_ff == ST_IDLE && launch && dec.legal && (dec.backdoor || dec.override)),
      .key_in    (key_ff[KEY_W-1:0]),
      .key_ref   (nv_key),
      .match_ff  (key_match),
      .fail_ff   (key_fail),
      .locked_ff ()
   );

   ////////////////////////////////////////////////////////////////////////
   // special mode pin: three stages, accepted once stages two and three agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sm1_ff  <= 1'b0;
         sm2_ff  <= 1'b0;
         sm3_ff  <= 1'b0;
         spec_ff <= 1'b0;
      end else begin
         sm1_ff <= special_mode;
         sm2_ff <= sm1_ff;
         sm3_ff <= sm2_ff;
         if (sm2_ff == sm3_ff) begin
            spec_ff <= sm3_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // launch checks; a write while busy is an access error, never queued
   assign launch      = wr && addr == REG_CMD;
   assign prog_open   = (prot_ff[PB_LOW] && prot_ff[PB_HIGH] && prot_ff[PB_POPN]) || povr_ff;
   assign data_open   = prot_ff[PB_DOPN] || dovr_ff;
   assign is_data_blk = addr_ff[AW-1];
   assign refuse_ill  = !dec.legal || (dec.op == OP_MRG_FLD && !spec_ff);                  // [R17] [R15]
   assign refuse_viol = (dec.op == OP_ERS_ALL && !dec.unsec && !(prog_open && data_open))  // [R8]
                     || (dec.op == OP_ERS_BLK && !is_data_blk && !prog_open)                // [R10]
                     || (dec.op == OP_ERS_BLK && is_data_blk && !data_open);
   assign refuse_acc  = st_ff != ST_IDLE
                     || ((dec.op == OP_RD_ONCE || dec.op == OP_PG_ONCE) && addr_ff >= ONCE_BYTES) // [R4]
                     || (dec.op == OP_PG_ONCE && once_used);                                // [R6]
   assign accept      = launch && !refuse_ill && !refuse_viol && !refuse_acc;

   ////////////////////////////////////////////////////////////////////////
   // sequencer state
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_st = (dec.backdoor || dec.override) ? ST_KEY : ST_ISSUE;
            end
         end
         ST_ISSUE: nxt_st = ST_WAIT;
         ST_WAIT: begin
            if (eng_done) begin
               // unsecure chains a verify after its erase
               nxt_st = (unsec_ff && eng_req_ff.op == OP_ERS_ALL && !eng_fail) ? ST_ISSUE : ST_FIN; // [R12]
            end
         end
         ST_KEY:  nxt_st = (key_match || key_fail) ? ST_FIN : ST_KEY;
         ST_FIN:  nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff   <= ST_IDLE;
         busy_ff <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         busy_ff <= nxt_st != ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // engine request: one-cycle valid, fields held until the next request
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         eng_req_ff <= '0;
         unsec_ff   <= 1'b0;
      end else begin
         eng_req_ff.valid <= 1'b0;
         if (st_ff == ST_IDLE && accept && !dec.backdoor && !dec.override) begin
            eng_req_ff.valid <= 1'b1;         // [R1] [R2] [R3] [R5] [R7] [R9] [R11] [R14]
            eng_req_ff.op    <= dec.op;
            eng_req_ff.addr  <= addr_ff;
            eng_req_ff.data  <= data_ff;
            eng_req_ff.count <= cnt_ff;
            unsec_ff         <= dec.unsec;
         end else if (st_ff == ST_WAIT && nxt_st == ST_ISSUE) begin
            eng_req_ff.valid <= 1'b1;
            eng_req_ff.op    <= OP_VFY_ALL;   // [R12]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_ff <= '0;
         data_ff <= '0;
         cnt_ff  <= '0;
         prot_ff <= '0;
         key_ff  <= '0;
      end else begin
         if (wr && addr == REG_ADDR) begin
            addr_ff <= wdata[AW-1:0];
         end
         if (wr && addr == REG_CNT) begin
            cnt_ff <= wdata[15:0];
         end
         if (wr && addr == REG_PROT) begin
            prot_ff <= wdata[3:0];
         end
         if (wr && addr == REG_KEY) begin
            key_ff <= {key_ff[31:0], wdata};
         end
         // read-once result lands in the low data word
         if (st_ff == ST_WAIT && eng_done && eng_req_ff.op == OP_RD_ONCE) begin
            data_ff[31:0] <= eng_rdata;       // [R4]
         end else if (wr && addr == REG_DAT0) begin
            data_ff[31:0] <= wdata;
         end
         if (wr && addr == REG_DAT1) begin
            data_ff[63:32] <= wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky flags: write one clears, a hardware set in the same cycle wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         done_ff  <= 1'b0;
         ill_ff   <= 1'b0;
         viol_ff  <= 1'b0;
         acc_ff   <= 1'b0;
         vfail_ff <= 1'b0;
      end else begin
         if (wr && addr == REG_STAT) begin
            done_ff  <= done_ff && !wdata[SB_DONE];
            ill_ff   <= ill_ff && !wdata[SB_ILL];
            viol_ff  <= viol_ff && !wdata[SB_VIOL];
            acc_ff   <= acc_ff && !wdata[SB_ACC];
            vfail_ff <= vfail_ff && !wdata[SB_VFAIL];
         end
         if (st_ff == ST_FIN) begin
            done_ff <= 1'b1;
         end
         if (launch && refuse_ill && !refuse_acc) begin
            ill_ff <= 1'b1;                   // [R17]
         end
         if (launch && refuse_viol && !refuse_ill && !refuse_acc) begin
            viol_ff <= 1'b1;                  // [R8] [R10]
         end
         if (launch && refuse_acc) begin
            acc_ff <= 1'b1;
         end
         if ((st_ff == ST_WAIT && eng_done && eng_fail) || (st_ff == ST_KEY && key_fail)) begin
            vfail_ff <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // security and temporary protection override
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         secured_ff <= 1'b1;
         povr_ff    <= 1'b0;
         dovr_ff    <= 1'b0;
         ovr_cmd_ff <= 1'b0;
      end else begin
         if (st_ff == ST_IDLE && accept) begin
            ovr_cmd_ff <= dec.override;
         end
         if (st_ff == ST_WAIT && eng_done && !eng_fail && unsec_ff && eng_req_ff.op == OP_VFY_ALL) begin
            secured_ff <= 1'b0;               // [R12]
         end
         if (st_ff == ST_KEY && key_match && !ovr_cmd_ff) begin
            secured_ff <= 1'b0;               // [R13]
         end
         // override lasts until reset or a new override with bits clear
         if (st_ff == ST_KEY && key_match && ovr_cmd_ff) begin
            povr_ff <= data_ff[0];            // [R16]
            dovr_ff <= data_ff[1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port, data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= '0;
         if (rd) begin
            case (addr)
               REG_CMD:  rdata_ff <= {28'h0000000, eng_req_ff.op};
               REG_ADDR: rdata_ff <= {8'h00, addr_ff};
               REG_DAT0: rdata_ff <= data_ff[31:0];
               REG_DAT1: rdata_ff <= data_ff[63:32];
               REG_CNT:  rdata_ff <= {16'h0000, cnt_ff};
               REG_PROT: rdata_ff <= {28'h0000000, prot_ff};
               REG_STAT: rdata_ff <= {23'h000000, dovr_ff, povr_ff, secured_ff, vfail_ff,
                                      acc_ff, viol_ff, ill_ff, done_ff, busy_ff};
               default:  rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_ILLEGAL: assert property (launch && !dec.legal && st_ff == ST_IDLE |=> ill_ff && !eng_req_ff.valid) // [R17]
      else $error("illegal code not flagged");
   AST_ERASE_ALL_GATE: assert property (launch && st_ff == ST_IDLE && wdata[7:0] == C_ERS_ALL
      && !(prog_open && data_open) |=> viol_ff ##0 !eng_req_ff.valid [*3]) // [R8]
      else $error("erase all started while protected");
   AST_BLOCK_GATE: assert property (launch && st_ff == ST_IDLE && wdata[7:0] == C_ERS_BLK && !is_data_blk
      && !prog_open |=> !busy_ff && viol_ff) // [R10]
      else $error("block erase started while protected");
   AST_VERIFY_ALL: assert property (accept && st_ff == ST_IDLE && wdata[7:0] == C_VFY_ALL
      |=> eng_req_ff.valid && eng_req_ff.op == OP_VFY_ALL ##1 !eng_req_ff.valid) // [R1]
      else $error("verify all not issued");
   AST_PROGRAM: assert property (accept && st_ff == ST_IDLE && wdata[7:0] == C_PROG
      |=> eng_req_ff.valid && eng_req_ff.op == OP_PROG && eng_req_ff.data == $past(data_ff)) // [R5]
      else $error("phrase program not issued");
   AST_SECTOR: assert property (accept && st_ff == ST_IDLE && wdata[7:0] == C_ERS_SEC
      |=> eng_req_ff.op == OP_ERS_SEC && eng_req_ff.addr == $past(addr_ff)) // [R11]
      else $error("sector erase not issued");
   AST_UNSECURE: assert property (st_ff == ST_WAIT && eng_done && !eng_fail && unsec_ff
      && eng_req_ff.op == OP_ERS_ALL |=> eng_req_ff.valid && eng_req_ff.op == OP_VFY_ALL
      && secured_ff == $past(secured_ff)) // [R12]
      else $error("unsecure did not chain verify");
   AST_FIELD_MODE: assert property (launch && st_ff == ST_IDLE && wdata[7:0] == C_MRG_FLD && !spec_ff
      |=> ill_ff && !busy_ff) // [R15]
      else $error("field margin accepted outside special mode");
   AST_ONCE_LOCK: assert property (launch && wdata[7:0] == C_PG_ONCE && once_used
      |=> acc_ff && !eng_req_ff.valid) // [R6]
      else $error("second one-time program accepted");
   AST_BACKDOOR: assert property (st_ff == ST_KEY && key_match && !ovr_cmd_ff |=> !secured_ff ##1 !busy_ff) // [R13]
      else $error("matching key did not release security");

   COV_UNSEC: cover property (st_ff == ST_WAIT && unsec_ff && eng_req_ff.op == OP_VFY_ALL && eng_done);
   COV_OVR:   cover property (st_ff == ST_KEY && key_match && ovr_cmd_ff);
   COV_VIOL:  cover property (launch && refuse_viol);
   COV_READ1: cover property (st_ff == ST_WAIT && eng_done && eng_req_ff.op == OP_RD_ONCE);
endmodule

// ===== verif/fcd_eng_model.sv
// Purpose: behavioural program/erase engine, no flash array behind it
// Assumes: one request outstanding, done two or seven cycles after it
// Notes:   fail and read data scramble outside the done pulse
`timescale 1ns/1ps
module fcd_eng_model import fcd_pkg::*; (
   input  wire fcd_req_t    req,
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        fail_next,
   input  wire logic        slow,
   output logic             eng_done,
   output logic             eng_fail,
   output logic [31:0]      eng_rdata
);
   logic [2:0] cnt_ff;
   ////////////////////////////////////////////////////////////
   // every op is carried out after a short or a long wait
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 3'h0;
         eng_done <= 1'b0;
         eng_fail <= 1'b0;
         eng_rdata <= 32'h0;
      end else begin
         eng_done <= 1'b0;
         eng_fail <= ~eng_fail; // stale value must never look valid
         eng_rdata <= eng_rdata + 32'h9E3779B9;
         if (req.valid) begin
            cnt_ff <= slow ? 3'h6 : 3'h1;
         end else if (cnt_ff == 3'h1) begin
            eng_done <= 1'b1;
            eng_fail <= fail_next;
            eng_rdata <= {8'hA5, req.addr};
            cnt_ff <= 3'h0;
         end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
         end
      end
   end
endmodule

// ===== verif/fcd_top_tb.sv
// Purpose: self-checking bench of the flash command decoder
// Assumes: register port with read data one cycle after rd
// Notes:   status reads and engine requests are checked from queues
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module fcd_top_tb import fcd_pkg::*; ();
   logic sys_clk, rst, wr, rd, once_used, special_mode, fail_next, slow;
   logic eng_done, eng_fail, secured_ff, busy_ff, rd_q;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata_ff, eng_rdata, base, w_e, w_m, a_v;
   logic [15:0] cnt_v;
   logic [63:0] nv_key, phrase;
   fcd_req_t    eng_req_ff;
   int          bad_count, tests_run;
   logic [31:0] exp_q[$], msk_q[$];
   fcd_op_t     op_q[$], w_o;
   logic [7:0]  bad[6] = '{8'h05, 8'h0F, 8'h10, 8'h11, 8'h12, C_MRG_FLD};
   logic [7:0]  cmds[10] = '{C_VFY_ALL, C_VFY_BLK, C_VFY_SEC, C_RD_ONCE, C_PROG, C_PG_ONCE,
                             C_ERS_ALL, C_ERS_BLK, C_ERS_SEC, C_MRG_USR};
   fcd_op_t     ops[10] = '{OP_VFY_ALL, OP_VFY_BLK, OP_VFY_SEC, OP_RD_ONCE, OP_PROG, OP_PG_ONCE,
                            OP_ERS_ALL, OP_ERS_BLK, OP_ERS_SEC, OP_MRG_USR};

   fcd_top fcd_top_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_ff(rdata_ff), .eng_req_ff(eng_req_ff), .eng_done(eng_done), .eng_fail(eng_fail),
      .eng_rdata(eng_rdata), .once_used(once_used), .nv_key(nv_key), .special_mode(special_mode),
      .secured_ff(secured_ff), .busy_ff(busy_ff));
   fcd_eng_model fcd_eng_model_inst (.req(eng_req_ff), .sys_clk(sys_clk), .rst(rst), .fail_next(fail_next),
      .slow(slow), .eng_done(eng_done), .eng_fail(eng_fail), .eng_rdata(eng_rdata));

   ////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // watcher: read data and engine requests against the oldest notes
   always @(posedge sys_clk) begin
      rd_q <= rd;
      if (rd_q) begin
         w_e = exp_q.pop_front();
         w_m = msk_q.pop_front();
         `CHK(rdata_ff & w_m, w_e & w_m)
      end
      if (eng_req_ff.valid === 1'b1) begin
         if (op_q.size() == 0) begin
            `CHK(eng_req_ff.valid, 1'b0)
         end else begin
            // pop once: the macro names its expected value twice
            w_o = op_q.pop_front();
            `CHK(eng_req_ff.op, w_o)
         end
         `CHK(eng_req_ff.addr, a_v[AW-1:0])
         if (eng_req_ff.op === OP_PROG) `CHK(eng_req_ff.data, phrase)
         if (eng_req_ff.op === OP_VFY_SEC) `CHK(eng_req_ff.count, cnt_v)
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge sys_clk);
      rd <= 1'b0;
   endtask

   // launch, wait for busy to drop, note status, clear the flags
   task automatic run(input logic [7:0] code, input logic [31:0] a, input logic [31:0] st,
                      input logic [31:0] m);
      int i;
      a_v = a;
      wr_reg(REG_ADDR, a);
      wr_reg(REG_CMD, {24'h000000, code});
      @(posedge sys_clk);
      for (i = 0; i < 200 && busy_ff !== 1'b0; i++) @(posedge sys_clk);
      rd_reg(REG_STAT, st, m);
      wr_reg(REG_STAT, 32'h0000003E);
      $display("test of command %h done", code);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      #(30000 * 40);
      bad_count++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial begin
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
      once_used = 1'b0; special_mode = 1'b0; fail_next = 1'b0; slow = 1'b0;
      bad_count = 0; tests_run = 0; base = 32'h00000040; phrase = 64'h0;
      a_v = 32'h0; cnt_v = 16'h0000;
      void'($urandom(32'h0088DD79));
      nv_key = {$urandom, $urandom};
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      `CHK(secured_ff, 1'b1)
      // unsupported codes and field margin outside special mode
      foreach (bad[i]) run(bad[i], 32'h0, base | 32'h4, 32'h1FD);
      wr_reg(REG_PROT, 32'h7);
      run(C_ERS_ALL, 32'h0, base | 32'h8, 32'h1FD);
      wr_reg(REG_PROT, 32'h3);
      run(C_ERS_BLK, 32'h0, base | 32'h8, 32'h1FD);
      wr_reg(REG_PROT, 32'hF);
      foreach (cmds[i]) begin
         slow <= 1'($urandom);
         phrase = {$urandom, $urandom};
         cnt_v = 16'($urandom);
         wr_reg(REG_DAT0, phrase[31:0]);
         wr_reg(REG_DAT1, phrase[63:32]);
         wr_reg(REG_CNT, {16'h0000, cnt_v});
         op_q.push_back(ops[i]);
         a_v = (cmds[i] == C_ERS_BLK) ? 32'h00800000 : {26'h0, 6'($urandom)};
         run(cmds[i], a_v, base | 32'h2, 32'h1FF);
         if (cmds[i] == C_RD_ONCE) rd_reg(REG_DAT0, {8'hA5, a_v[23:0]}, 32'hFFFFFFFF);
      end
      // one-time field: used already, and first address past the field
      once_used <= 1'b1;
      run(C_PG_ONCE, 32'h0, base | 32'h10, 32'h1FD);
      once_used <= 1'b0;
      run(C_RD_ONCE, 32'h40, base | 32'h10, 32'h1FD);
      fail_next <= 1'b1;
      op_q.push_back(OP_VFY_BLK);
      run(C_VFY_BLK, 32'h0, base | 32'h20, 32'h1FD);
      fail_next <= 1'b0;
      special_mode <= 1'b1;
      repeat (6) @(posedge sys_clk);
      op_q.push_back(OP_MRG_FLD);
      run(C_MRG_FLD, 32'h0, base | 32'h2, 32'h1FF);
      // key commands: override, wrong key, then right key while locked
      wr_reg(REG_KEY, nv_key[63:32]);
      wr_reg(REG_KEY, nv_key[31:0]);
      wr_reg(REG_DAT0, 32'h3);
      base = base | 32'h180;
      run(C_PROT_OV, 32'h0, base, 32'h1FD);
      wr_reg(REG_KEY, ~nv_key[63:32]);
      wr_reg(REG_KEY, nv_key[31:0]);
      run(C_BACKDR, 32'h0, base | 32'h20, 32'h1FD);
      wr_reg(REG_KEY, nv_key[63:32]);
      wr_reg(REG_KEY, nv_key[31:0]);
      run(C_BACKDR, 32'h0, base | 32'h20, 32'h1FD);
      op_q.push_back(OP_ERS_ALL);
      op_q.push_back(OP_VFY_ALL);
      base = base & 32'hFFFFFFBF;
      run(C_UNSEC, 32'h0, base, 32'h1FD);
      `CHK(secured_ff, 1'b0)
      rd_reg(8'h20, 32'h0, 32'hFFFFFFFF);
      repeat (3) @(posedge sys_clk);
      `CHK(op_q.size(), 0)
      report_and_stop();
   end
endmodule
